// file: core/rcb_cal_next.sv
`timescale 1ns/1ps
module rcb_cal_next
  import rcb_pkg::*;
(
  input wire logic [TM_W-1:0] tm_in,
  input wire logic [DT_W-1:0] dt_in,
  input wire logic h12,
  output logic [TM_W-1:0] tm_out,
  output logic [DT_W-1:0] dt_out
);
  logic [7:0] sec, mins, hr, day, mon, yr, last;
  logic [2:0] wday;
  logic pm, leap, carry;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = v + 8'h01;
    end
  endfunction

  // ----------------------------------------------------------------
  // one-second step of the bcd calendar
  // ----------------------------------------------------------------
  always_comb begin
    sec = {1'b0, tm_in[6:0]};
    mins = {1'b0, tm_in[14:8]};
    hr = {2'b00, tm_in[21:16]};
    pm = tm_in[22];
    day = {2'b00, dt_in[5:0]};
    mon = {3'b000, dt_in[12:8]};
    wday = dt_in[15:13];
    yr = dt_in[23:16];
    carry = 1'b0;
    // leap when bcd year divisible by four
    leap = (!yr[4] && (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8)) ||
           (yr[4] && (yr[3:0] == 4'h2 || yr[3:0] == 4'h6));
    if (mon == 8'h02) begin
      last = leap ? 8'h29 : 8'h28;
    end else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11) begin
      last = 8'h30;
    end else begin
      last = 8'h31;
    end
    if (sec != 8'h59) begin
      sec = bcd_inc(sec);
    end else begin
      sec = 8'h00;
      if (mins != 8'h59) begin
        mins = bcd_inc(mins);
      end else begin
        mins = 8'h00;
        if (h12) begin
          if (hr == 8'h12) begin
            hr = 8'h01;
          end else if (hr == 8'h11) begin
            hr = 8'h12;
            carry = pm; // 11:59:59 pm rolls into a new day
            pm = !pm;
          end else begin
            hr = bcd_inc(hr);
          end
        end else if (hr == 8'h23) begin
          hr = 8'h00;
          carry = 1'b1;
        end else begin
          hr = bcd_inc(hr);
        end
      end
    end
    if (carry) begin
      wday = (wday == 3'd7) ? 3'd1 : wday + 3'd1;
      if (day == last) begin
        day = 8'h01;
        if (mon == 8'h12) begin
          mon = 8'h01;
          yr = (yr == 8'h99) ? 8'h00 : bcd_inc(yr);
        end else begin
          mon = bcd_inc(mon);
        end
      end else begin
        day = bcd_inc(day);
      end
    end
    tm_out = {pm, hr[5:0], 1'b0, mins[6:0], 1'b0, sec[6:0]};
    dt_out = {yr, wday, mon[4:0], 2'b00, day[5:0]};
  end
endmodule

// file: core/rcb_pin_filter.sv
`timescale 1ns/1ps
module rcb_pin_filter
  import rcb_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic pin,
  input wire logic [1:0] filt_sel,
  output logic event_pulse
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic lvl;
    logic [3:0] cnt;
    logic evt;
  } rcb_filt_type;

  rcb_filt_type s_reg;
  rcb_filt_type s_next;
  logic [3:0] thr;

  // ----------------------------------------------------------------
  // sync, then level must differ for 1/2/4/8 samples
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    thr = 4'h1 << filt_sel;
    s_next.sync1 = pin;
    s_next.sync2 = s_reg.sync1;
    s_next.evt = 1'b0;
    if (s_reg.sync2 != s_reg.lvl) begin
      if (s_reg.cnt + 4'h1 == thr) begin
        s_next.lvl = s_reg.sync2;
        s_next.cnt = 4'h0;
        s_next.evt = s_reg.sync2; // rising edge only
      end else begin
        s_next.cnt = s_reg.cnt + 4'h1;
      end
    end else begin
      s_next.cnt = 4'h0; // glitch shorter than filter is dropped
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign event_pulse = s_reg.evt;
endmodule

// file: core/rcb_pkg.sv
package rcb_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int SEC_TIME_NS = 1_000_000_000;
  localparam int SEC_CYCLES_DEF = SEC_TIME_NS / CLK_PERIOD_NS;
  localparam int CAL_PPM_WINDOW = 1_000_000;
  localparam int BKP_WORDS = 32;
  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [8:0] OFS_TIME = 9'h000;
  localparam logic [8:0] OFS_DATE = 9'h004;
  localparam logic [8:0] OFS_SUBSEC = 9'h008;
  localparam logic [8:0] OFS_CTRL = 9'h00C;
  localparam logic [8:0] OFS_ALARM_A = 9'h010;
  localparam logic [8:0] OFS_ALARM_B = 9'h014;
  localparam logic [8:0] OFS_WUT = 9'h018;
  localparam logic [8:0] OFS_CAL = 9'h01C;
  localparam logic [8:0] OFS_SHIFT = 9'h020;
  localparam logic [8:0] OFS_STATUS = 9'h024;
  localparam logic [8:0] OFS_MASK = 9'h028;
  localparam logic [8:0] OFS_TS_TIME = 9'h02C;
  localparam logic [8:0] OFS_TS_DATE = 9'h030;
  localparam logic [8:0] OFS_TS_SUB = 9'h034;
  localparam logic [8:0] OFS_BKP = 9'h100;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_H12 = 0;
  localparam int CTRL_ALM_EN = 1;
  localparam int CTRL_WUT_EN = 3;
  localparam int CTRL_WUT_SEL = 4;
  localparam int CTRL_TAMP_EN = 6;
  localparam int CTRL_TS_EN = 9;
  localparam int CTRL_TAMP_TS = 10;
  localparam int CTRL_FILT = 11;
  localparam int CTRL_WAKE_EN = 13;
  localparam int CTRL_W = 20;
  localparam int STS_ALM = 0;
  localparam int STS_WUT = 2;
  localparam int STS_TS = 3;
  localparam int STS_TAMP = 4;
  localparam int STS_W = 7;
  localparam int CAL_MAG_W = 9;
  localparam int CAL_NEG = 15;
  localparam int SHIFT_W = 15;
  localparam int SHIFT_DIR = 31;
  localparam int TM_W = 23;
  localparam int DT_W = 24;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [TM_W-1:0] TM_RST = 23'h000000;
  localparam logic [DT_W-1:0] DT_RST = 24'h002101;
  localparam logic [CTRL_W-1:0] CTRL_RST = 20'h00000;
endpackage

// file: core/rcb_rtc.sv
// The Avalon-MM interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// - thirty-two 32-bit backup words, 128 bytes
// - backup words survive system and power reset
// - backup words survive leaving standby
// - bcd calendar, subsecond to year, 12/24h
// - date rolls over at 28/29/30/31
// - two alarms, each may wake device
// - wakeup timer, programmable resolution and period
// - time base shift by 1..32767 pulses
// - frequency calibration with 1 ppm steps
// - three tamper inputs with programmable filter
// - tamper event may wake device
// - timestamp captures calendar on pin or tamper
// - timestamp event may wake device
module rcb_rtc
  import rcb_pkg::*;
#(
  parameter int SEC_CYCLES = SEC_CYCLES_DEF,
  parameter int CAL_WINDOW = CAL_PPM_WINDOW
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [8:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [2:0] tamper_pin,
  input wire logic stamp_pin,
  output logic irq,
  output logic wake_req
);
  typedef struct packed {
    logic [31:0] sub;
    logic [TM_W-1:0] tm;
    logic [DT_W-1:0] dt;
    logic [CTRL_W-1:0] ctrl;
    logic [1:0][TM_W-1:0] alm;
    logic [15:0] wut_reload;
    logic [15:0] wut_cnt;
    logic [11:0] presc;
    logic [15:0] cal;
    logic [19:0] cal_cnt;
    logic [SHIFT_W-1:0] shift_cnt;
    logic shift_dir;
    logic [STS_W-1:0] sts;
    logic [STS_W-1:0] mask;
    logic [TM_W-1:0] ts_tm;
    logic [DT_W-1:0] ts_dt;
    logic [31:0] ts_sub;
    logic waitreq;
    logic [31:0] rdata;
    logic irq;
    logic wake;
  } rcb_state_type;

  rcb_state_type s_reg;
  rcb_state_type s_next;
  logic [31:0] bkp_mem [BKP_WORDS];
  logic [TM_W-1:0] tm_inc;
  logic [DT_W-1:0] dt_inc;
  logic [3:0] pin_evt;
  logic [3:0] pin_raw;
  logic [8:0] wa;
  logic acc, bkp_sel, bkp_we;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        merge[8*i +: 8] = nw[8*i +: 8];
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // pin filters: three tamper inputs, then the timestamp input
  // ----------------------------------------------------------------
  assign pin_raw = {stamp_pin, tamper_pin};
  generate
    for (genvar g = 0; g < 4; g++) begin : g_pin
      rcb_pin_filter u_filt (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .pin(pin_raw[g]),
        .filt_sel((g < 3) ? s_reg.ctrl[CTRL_FILT +: 2] : 2'b00),
        .event_pulse(pin_evt[g])
      );
    end
  endgenerate

  rcb_cal_next u_cal (
    .tm_in(s_reg.tm),
    .dt_in(s_reg.dt),
    .h12(s_reg.ctrl[CTRL_H12]),
    .tm_out(tm_inc),
    .dt_out(dt_inc)
  );

  // bus decode; the slave answers once per request
  assign wa = {avs_address[8:2], 2'b00};
  assign acc = (avs_read || avs_write) && s_reg.waitreq;
  assign bkp_sel = (avs_address[8:7] == OFS_BKP[8:7]);
  assign bkp_we = acc && avs_write && bkp_sel;

  // ----------------------------------------------------------------
  // backup store: no reset on purpose, contents outlive nrst
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (ce && bkp_we) begin
      bkp_mem[avs_address[6:2]] <= merge(bkp_mem[avs_address[6:2]], avs_writedata,
                                         avs_byteenable);
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [1:0] step;
    logic sec_tick, wut_tick, rd_clr, ts_trig;
    logic [2:0] tamp_evt;
    logic [STS_W-1:0] sts_set;
    logic [31:0] rd;
    logic [31:0] wv;
    step = 2'd1;
    sec_tick = 1'b0;
    wut_tick = 1'b0;
    rd_clr = 1'b0;
    ts_trig = 1'b0;
    tamp_evt = 3'b000;
    sts_set = '0;
    rd = 32'h0000_0000;
    wv = 32'h0000_0000;
    s_next = s_reg;

    // calibration window: the first |cal| pulses of each million
    // are doubled or swallowed, one pulse is one ppm
    s_next.cal_cnt = (s_reg.cal_cnt == 20'(CAL_WINDOW - 1)) ? 20'h0_0000
                     : s_reg.cal_cnt + 20'h0_0001;
    if (20'(s_reg.cal[CAL_MAG_W-1:0]) > s_reg.cal_cnt) begin
      step = s_reg.cal[CAL_NEG] ? 2'd0 : 2'd2;
    end else if (s_reg.shift_cnt != '0) begin
      // shift yields to calibration so a step never exceeds two
      step = s_reg.shift_dir ? 2'd0 : 2'd2;
      s_next.shift_cnt = s_reg.shift_cnt - 15'h0001;
    end

    // subsecond counts down; wrap keeps extra pulses in the period
    if (s_reg.sub < 32'(step)) begin
      s_next.sub = s_reg.sub + 32'(SEC_CYCLES) - 32'(step);
      sec_tick = 1'b1;
    end else begin
      s_next.sub = s_reg.sub - 32'(step);
    end

    // calendar and alarms
    if (sec_tick) begin
      s_next.tm = tm_inc;
      s_next.dt = dt_inc;
      for (int i = 0; i < 2; i++) begin
        if (s_reg.ctrl[CTRL_ALM_EN + i] && tm_inc == s_reg.alm[i]) begin
          sts_set[STS_ALM + i] = 1'b1;
        end
      end
    end

    // wakeup timer, resolution from the prescaler taps or the second tick
    s_next.presc = s_reg.presc + 12'h001;
    case (s_reg.ctrl[CTRL_WUT_SEL +: 2])
      2'd0: wut_tick = (s_reg.presc[3:0] == 4'hF);
      2'd1: wut_tick = (s_reg.presc[7:0] == 8'hFF);
      2'd2: wut_tick = (s_reg.presc == 12'hFFF);
      default: wut_tick = sec_tick;
    endcase
    if (!s_reg.ctrl[CTRL_WUT_EN]) begin
      s_next.wut_cnt = s_reg.wut_reload;
    end else if (wut_tick) begin
      if (s_reg.wut_cnt == 16'h0000) begin
        s_next.wut_cnt = s_reg.wut_reload;
        sts_set[STS_WUT] = 1'b1;
      end else begin
        s_next.wut_cnt = s_reg.wut_cnt - 16'h0001;
      end
    end

    // tamper and timestamp
    tamp_evt = pin_evt[2:0] & s_reg.ctrl[CTRL_TAMP_EN +: 3];
    sts_set[STS_TAMP +: 3] = tamp_evt;
    ts_trig = (pin_evt[3] && s_reg.ctrl[CTRL_TS_EN]) ||
              ((|tamp_evt) && s_reg.ctrl[CTRL_TAMP_TS]);
    if (ts_trig) begin
      s_next.ts_tm = s_reg.tm;
      s_next.ts_dt = s_reg.dt;
      s_next.ts_sub = s_reg.sub;
      sts_set[STS_TS] = 1'b1;
    end

    // bus slave: waitrequest drops for one cycle per request
    s_next.waitreq = 1'b1;
    if (acc) begin
      s_next.waitreq = 1'b0;
      case (wa)
        OFS_TIME: rd = 32'(s_reg.tm);
        OFS_DATE: rd = 32'(s_reg.dt);
        OFS_SUBSEC: rd = s_reg.sub;
        OFS_CTRL: rd = 32'(s_reg.ctrl);
        OFS_ALARM_A: rd = 32'(s_reg.alm[0]);
        OFS_ALARM_B: rd = 32'(s_reg.alm[1]);
        OFS_WUT: rd = {s_reg.wut_cnt, s_reg.wut_reload};
        OFS_CAL: rd = {16'h0000, s_reg.cal[CAL_NEG], 6'h00, s_reg.cal[CAL_MAG_W-1:0]};
        OFS_SHIFT: rd = {s_reg.shift_dir, 16'h0000, s_reg.shift_cnt};
        OFS_STATUS: rd = 32'(s_reg.sts);
        OFS_MASK: rd = 32'(s_reg.mask);
        OFS_TS_TIME: rd = 32'(s_reg.ts_tm);
        OFS_TS_DATE: rd = 32'(s_reg.ts_dt);
        OFS_TS_SUB: rd = s_reg.ts_sub;
        default: rd = bkp_sel ? bkp_mem[avs_address[6:2]] : 32'h0000_0000;
      endcase
      // lanes merged once; a call result cannot be part-selected
      wv = merge(rd, avs_writedata, avs_byteenable);
      if (avs_read) begin
        s_next.rdata = rd;
        rd_clr = (wa == OFS_STATUS);
      end else begin
        case (wa)
          OFS_TIME: s_next.tm = wv[TM_W-1:0];
          OFS_DATE: s_next.dt = wv[DT_W-1:0];
          OFS_CTRL: s_next.ctrl = wv[CTRL_W-1:0];
          OFS_ALARM_A: s_next.alm[0] = wv[TM_W-1:0];
          OFS_ALARM_B: s_next.alm[1] = wv[TM_W-1:0];
          OFS_WUT: s_next.wut_reload = wv[15:0];
          OFS_CAL: begin
            s_next.cal = wv[15:0];
          end
          OFS_SHIFT: begin
            // refused while a shift is still running
            if (s_reg.shift_cnt == '0) begin
              s_next.shift_cnt = avs_writedata[SHIFT_W-1:0];
              s_next.shift_dir = avs_writedata[SHIFT_DIR];
            end
          end
          OFS_MASK: s_next.mask = wv[STS_W-1:0];
          default: s_next.rdata = s_reg.rdata;
        endcase
      end
    end

    // sticky status: an event in the clearing cycle survives
    s_next.sts = (rd_clr ? '0 : s_reg.sts) | sts_set;
    s_next.irq = |(s_next.sts & s_next.mask);
    s_next.wake = |(s_next.sts & s_next.ctrl[CTRL_WAKE_EN +: STS_W]);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
      s_reg.sub <= 32'(SEC_CYCLES - 1);
      s_reg.tm <= TM_RST;
      s_reg.dt <= DT_RST;
      s_reg.ctrl <= CTRL_RST;
      s_reg.waitreq <= 1'b1;
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign avs_readdata = s_reg.rdata;
  assign avs_waitrequest = s_reg.waitreq;
  assign irq = s_reg.irq;
  assign wake_req = s_reg.wake;
endmodule

// file: dv/rcb_pin_model.sv
`timescale 1ns/1ps
module rcb_pin_model (
  input wire logic clk,
  output logic [2:0] tamper_pin,
  output logic stamp_pin
);
  // switches rest low, as if pulled down
  initial begin
    tamper_pin = 3'h0;
    stamp_pin = 1'b0;
  end
  // one high pulse of len clocks; line 3 is the stamp source
  task automatic pulse(input int line, input int len);
    @(posedge clk);
    if (line == 3) begin
      stamp_pin <= 1'b1;
    end else begin
      tamper_pin[line] <= 1'b1;
    end
    repeat (len) @(posedge clk);
    tamper_pin <= 3'h0;
    stamp_pin <= 1'b0;
  endtask
endmodule

// file: dv/rcb_rtc_checker.sv
`timescale 1ns/1ps
module rcb_rtc_checker (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic irq,
  input wire logic wake_req
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // ----------------------------------------------------------------
  // bus handshake steps
  // ----------------------------------------------------------------
  sequence s_taken;
    (avs_read || avs_write) && avs_waitrequest && ce;
  endsequence
  sequence s_answer;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  a_bus_answer: assert property (s_taken |=> !avs_waitrequest)
    else $error("request not answered in next cycle");
  a_wait_single: assert property (!avs_waitrequest && ce |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_idle: assert property (ce && !avs_read && !avs_write |=> avs_waitrequest)
    else $error("waitrequest low without a request");
  a_read_hold: assert property (s_answer |-> $stable(avs_readdata))
    else $error("read data moved after the answer");
  a_data_quiet: assert property (!$stable(avs_readdata) |-> !avs_waitrequest)
    else $error("read data changed outside an answer");
  // a frozen clock enable must hold waitrequest and irq
  a_ce_freeze: assert property (!ce |=> $stable(avs_waitrequest) && $stable(irq))
    else $error("outputs moved while clock enable low");
  // sticky events only drop through a register access
  a_irq_fall: assert property ($fell(irq) |-> $past(avs_read || avs_write))
    else $error("interrupt dropped without an access");
  a_wake_fall: assert property ($fell(wake_req) |-> $past(avs_read || avs_write))
    else $error("wake request dropped without an access");
  a_reset_quiet: assert property ($rose(nrst) |-> avs_waitrequest && !irq && !wake_req)
    else $error("outputs not at rest after reset");
endmodule
bind rcb_rtc rcb_rtc_checker i_rcb_rtc_checker (.clk(clk), .nrst(nrst), .ce(ce),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .irq(irq), .wake_req(wake_req));

// file: dv/rcb_rtc_tb.sv
`timescale 1ns/1ps
module rcb_rtc_tb
  import rcb_pkg::*;
;
  localparam int SECS = 20;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic [8:0] avs_address = 9'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic wake_req;
  logic [2:0] tamper_pin;
  logic stamp_pin;
  int num_errors = 0;
  int compares = 0;
  int seed = 32'h62D956C6;
  logic [31:0] rd;
  logic [31:0] bkp [32];
  logic [31:0] din [4];
  logic [31:0] dexp [4];
  always #4 clk = ~clk;
  rcb_rtc #(.SEC_CYCLES(SECS), .CAL_WINDOW(64)) i_rcb_rtc (.clk, .nrst, .ce, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .tamper_pin, .stamp_pin, .irq, .wake_req);
  rcb_pin_model i_rcb_pin_model (.clk, .tamper_pin, .stamp_pin);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] mkdate(logic [7:0] y, logic [2:0] w, logic [4:0] m,
                                         logic [5:0] d);
    return {8'h00, y, w, m, 2'b00, d};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // one access; held until waitrequest seen low, bounded
  task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest && n < 50);
    if (n >= 50) begin
      num_errors++;
      $display("[ERR] %0t bus hang", $time);
      end_sim();
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd_chk(input logic [8:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  task automatic do_reset();
    nrst <= 1'b0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
  endtask
  // align to a second tick so later waits land in a known second
  task automatic wait_tick();
    logic [31:0] s;
    bus(1'b0, OFS_TIME, 32'h0);
    s = rd;
    for (int n = 0; n < 30 && rd === s; n++) bus(1'b0, OFS_TIME, 32'h0);
    if (rd === s) check(rd, ~s);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int n;
    int len;
    logic [7:0] exp;
    din = '{mkdate(8'h23, 3'h2, 5'h02, 6'h28), mkdate(8'h24, 3'h2, 5'h02, 6'h28),
            mkdate(8'h24, 3'h7, 5'h04, 6'h30), mkdate(8'h99, 3'h5, 5'h12, 6'h31)};
    dexp = '{mkdate(8'h23, 3'h3, 5'h03, 6'h01), mkdate(8'h24, 3'h3, 5'h02, 6'h29),
             mkdate(8'h24, 3'h1, 5'h05, 6'h01), mkdate(8'h00, 3'h6, 5'h01, 6'h01)};
    do_reset();
    rd_chk(OFS_TIME, 32'h0);
    rd_chk(OFS_DATE, 32'h00002101);
    $display("reset values done");
    for (int i = 0; i < 32; i++) begin
      bkp[i] = $random(seed);
      bus(1'b1, OFS_BKP + 9'(i * 4), bkp[i]);
    end
    avs_byteenable <= 4'h1;
    bus(1'b1, OFS_BKP, 32'hFFFFFFA5);
    avs_byteenable <= 4'hF;
    bkp[0][7:0] = 8'hA5;
    bus(1'b1, 9'h0FC, 32'hFFFFFFFF);
    rd_chk(9'h0FC, 32'h0);
    do_reset();
    ce <= 1'b0;
    repeat (5) @(posedge clk);
    ce <= 1'b1;
    for (int i = 0; i < 32; i++) rd_chk(OFS_BKP + 9'(i * 4), bkp[i]);
    $display("backup words done");
    for (int k = 0; k < 4; k++) begin
      wait_tick();
      bus(1'b1, OFS_TIME, 32'h00235959);
      bus(1'b1, OFS_DATE, din[k]);
      repeat (SECS) @(posedge clk);
      rd_chk(OFS_TIME, 32'h0);
      rd_chk(OFS_DATE, dexp[k]);
    end
    // 12h mode: 11:59:59 pm rolls to 12:00:00 am and a new day
    wait_tick();
    bus(1'b1, OFS_CTRL, 32'h1);
    bus(1'b1, OFS_TIME, 32'h00515959);
    repeat (SECS) @(posedge clk);
    rd_chk(OFS_TIME, 32'h00120000);
    rd_chk(OFS_DATE, mkdate(8'h00, 3'h7, 5'h01, 6'h02));
    $display("calendar done");
    // both alarms, one second apart, wake enabled on every status bit
    wait_tick();
    bus(1'b1, OFS_TIME, 32'h0);
    bus(1'b1, OFS_ALARM_A, 32'h1);
    bus(1'b1, OFS_ALARM_B, 32'h2);
    bus(1'b1, OFS_CTRL, 32'hFE006);
    bus(1'b0, OFS_STATUS, 32'h0);
    repeat (30) @(posedge clk);
    check(32'(wake_req), 32'h1);
    bus(1'b0, OFS_STATUS, 32'h0);
    check(rd & 32'h3, 32'h3);
    bus(1'b1, OFS_WUT, 32'h1);
    bus(1'b1, OFS_CTRL, 32'h8);
    for (int k = 0; k < 3; k++) begin
      if (k == 2) bus(1'b1, OFS_CTRL, 32'h0);
      bus(1'b0, OFS_STATUS, 32'h0);
      repeat (60) @(posedge clk);
      bus(1'b0, OFS_STATUS, 32'h0);
      check(32'(rd[STS_WUT]), (k < 2) ? 32'h1 : 32'h0);
    end
    $display("alarm and wakeup done");
    // pins with each filter length; a pulse one short is refused
    bus(1'b1, OFS_MASK, 32'h7F);
    for (int f = 0; f < 4; f++) begin
      for (int t = 0; t < 4; t++) begin
        n = 1 << f;
        len = (t < 3 && f > 0 && ($random(seed) & 1)) ? n - 1 : n;
        exp = (t == 3) ? 8'h08 : (len == n) ? 8'((1 << (4 + t)) | 8) : 8'h00;
        bus(1'b1, OFS_CTRL, 32'hFE7C0 | 32'(f << CTRL_FILT));
        bus(1'b0, OFS_STATUS, 32'h0);
        i_rcb_pin_model.pulse(t, len);
        repeat (8) @(posedge clk);
        check(32'(irq), 32'(exp != 0));
        check(32'(wake_req), 32'(exp != 0));
        rd_chk(OFS_STATUS, 32'(exp));
        repeat (3) @(posedge clk);
        check(32'(irq), 32'h0);
      end
    end
    rd_chk(OFS_TS_DATE, mkdate(8'h00, 3'h7, 5'h01, 6'h02));
    bus(1'b1, OFS_MASK, 32'h0);
    i_rcb_pin_model.pulse(3, 1);
    repeat (8) @(posedge clk);
    check(32'(irq), 32'h0);
    check(32'(wake_req), 32'h1);
    rd_chk(OFS_STATUS, 32'h8);
    $display("pins done");
    bus(1'b1, OFS_CAL, 32'h8005);
    rd_chk(OFS_CAL, 32'h8005);
    bus(1'b1, OFS_SHIFT, 32'h1);
    repeat (12) @(posedge clk);
    rd_chk(OFS_SHIFT, 32'h0);
    $display("trim done");
    end_sim();
  end
endmodule
